// ===== converter_pkg.sv
package converter_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_NS = 2000;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // Widths and codes
  // ****************************************
  localparam int MAX_DAC = 8;
  localparam int NUM_CONV = 2;
  localparam int RAW_WIDTH = 18;
  localparam int MUX_WIDTH = 3;
  localparam int DAC_WIDTH = 16;
  localparam int WIDE_PAD_LO = 6;
  localparam int WIDE_PAD_HI = 8;
  localparam int NARROW_PAD_HI = 16;
  localparam int NARROW_DROP = 2;
  localparam logic signed [31:0] DAC_CODE_MIN = 32'sh00000000;
  localparam logic signed [31:0] DAC_CODE_MAX = 32'sh0000FFFF;
  localparam logic [4:0] ADC_CHAN_FIRST = 5'h01;
  localparam logic [4:0] ADC_CHAN_LAST = 5'h10;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [3:0] OP_DAC_NOW = 4'h1;
  localparam logic [3:0] OP_DAC_WRITE = 4'h2;
  localparam logic [3:0] OP_DAC_UPDATE = 4'h3;
  localparam logic [3:0] OP_MEASURE = 4'h4;
  localparam logic [3:0] OP_MEASURE_WIDE = 4'h5;
  localparam logic [3:0] OP_READ = 4'h6;
  localparam logic [3:0] OP_READ_WIDE = 4'h7;
  localparam logic [3:0] OP_SELECT_CONV1 = 4'h8;
  localparam logic [3:0] OP_SELECT_CONV2 = 4'h9;
  localparam logic [3:0] OP_START = 4'hA;
  localparam logic [3:0] OP_WAIT = 4'hB;

  typedef enum logic [2:0] {ST_IDLE, ST_SETTLE, ST_CONVERT, ST_WAIT_EOC, ST_FINISH} ctrl_state_t;

endpackage

// ===== conv_if.sv
`timescale 1ns/100ps
`default_nettype none
interface conv_if;
  logic sel_valid;
  logic [converter_pkg::MUX_WIDTH-1:0] sel_code;
  logic start;
  logic eoc_flag;
  logic [converter_pkg::RAW_WIDTH-1:0] raw;

  modport ctrl (output sel_valid, output sel_code, output start, input eoc_flag, input raw);
  modport unit (input sel_valid, input sel_code, input start, output eoc_flag, output raw);
endinterface
`default_nettype wire

// ===== conv_unit.sv
`timescale 1ns/100ps
`default_nettype none
module conv_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control side
  conv_if.unit cif,
  // Converter pins
  output logic [converter_pkg::MUX_WIDTH-1:0] mux_sel_reg,
  output logic start_pin_reg,
  input wire logic eoc_pin,
  input wire logic [converter_pkg::RAW_WIDTH-1:0] data_pin
);

  logic eoc_s1_reg, eoc_s2_reg, eoc_s3_reg;
  logic [converter_pkg::RAW_WIDTH-1:0] data_s1_reg, data_s2_reg, raw_reg;
  logic eoc_flag_reg;
  logic capture;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // End pin idles high; reset to that level so release gives no false edge
      eoc_s1_reg <= 1'b1;
      eoc_s2_reg <= 1'b1;
      eoc_s3_reg <= 1'b1;
      data_s1_reg <= '0;
      data_s2_reg <= '0;
    end else begin
      eoc_s1_reg <= eoc_pin;
      eoc_s2_reg <= eoc_s1_reg;
      eoc_s3_reg <= eoc_s2_reg;
      data_s1_reg <= data_pin;
      data_s2_reg <= data_s1_reg;
    end
  end

  assign capture = eoc_s2_reg && !eoc_s3_reg;

  // ****************************************
  // Multiplexer and start pins
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mux_sel_reg <= '0;
    end else if (cif.sel_valid) begin
      mux_sel_reg <= cif.sel_code;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      start_pin_reg <= 1'b0;
    end else begin
      start_pin_reg <= cif.start;
    end
  end

  // ****************************************
  // Result and end of conversion
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      raw_reg <= '0;
    end else if (capture) begin
      raw_reg <= data_s2_reg;
    end
  end

  // A finishing conversion wins over a start in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eoc_flag_reg <= 1'b1;
    end else if (capture) begin
      eoc_flag_reg <= 1'b1;
    end else if (cif.start) begin
      eoc_flag_reg <= 1'b0;
    end
  end

  assign cif.eoc_flag = eoc_flag_reg;
  assign cif.raw = raw_reg;

  mux_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    cif.sel_valid |=> mux_sel_reg == $past(cif.sel_code))
    else $error("multiplexer select did not follow request");
  eoc_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    (cif.start && !capture) |=> !eoc_flag_reg ##1 start_pin_reg == 1'b0)
    else $error("end of conversion flag not cleared by start");

endmodule
`default_nettype wire

// ===== analog_io_converter_control.sv
`timescale 1ns/100ps
`default_nettype none
module analog_io_converter_control #(
  parameter int NUM_DAC = 2,
  parameter int SETTLE_CYC = converter_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Command port
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_op,
  input wire logic [4:0] cmd_chan,
  input wire logic signed [31:0] cmd_value,
  output logic cmd_ready_reg,
  // Result port
  output logic [31:0] result_reg,
  output logic result_valid_reg,
  // Output converters
  output logic [NUM_DAC-1:0][converter_pkg::DAC_WIDTH-1:0] dac_code_reg,
  output logic dac_load_reg,
  // Input converters
  output logic [converter_pkg::NUM_CONV-1:0][converter_pkg::MUX_WIDTH-1:0] conv_mux_sel,
  output logic [converter_pkg::NUM_CONV-1:0] conv_start,
  input wire logic [converter_pkg::NUM_CONV-1:0] conv_eoc,
  input wire logic [converter_pkg::NUM_CONV-1:0][converter_pkg::RAW_WIDTH-1:0] conv_data
);

  if (NUM_DAC < 1 || NUM_DAC > converter_pkg::MAX_DAC) begin : g_bad_dac
    $error("NUM_DAC out of range");
  end
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
    $error("SETTLE_CYC out of range");
  end

  localparam int NC = converter_pkg::NUM_CONV;
  localparam int RW = converter_pkg::RAW_WIDTH;

  converter_pkg::ctrl_state_t state_reg;
  logic [15:0] settle_cnt_reg;
  logic [NUM_DAC-1:0][converter_pkg::DAC_WIDTH-1:0] dac_hold_reg;
  logic [NC-1:0] sel_valid_reg, start_reg, eoc_flags, wait_mask_reg;
  logic [converter_pkg::MUX_WIDTH-1:0] sel_code_reg;
  logic [NC-1:0][RW-1:0] raw_w;
  logic conv_idx_reg, wide_reg;
  logic meas_reg;
  logic accept;
  logic [4:0] chan_m1;
  logic [2:0] dac_idx;
  logic dac_ok;
  logic [RW-1:0] raw_sel;

  function automatic logic [15:0] clamp_code(input logic signed [31:0] v);
    if (v < converter_pkg::DAC_CODE_MIN) begin
      clamp_code = 16'h0000;
    end else if (v > converter_pkg::DAC_CODE_MAX) begin
      clamp_code = 16'hFFFF;
    end else begin
      clamp_code = v[15:0];
    end
  endfunction

  function automatic logic [31:0] format_result(input logic [RW-1:0] raw, input logic wide);
    if (wide) begin
      format_result = {{converter_pkg::WIDE_PAD_HI{1'b0}}, raw, {converter_pkg::WIDE_PAD_LO{1'b0}}};
    end else begin
      format_result = {{converter_pkg::NARROW_PAD_HI{1'b0}}, raw[RW-1:converter_pkg::NARROW_DROP]};
    end
  endfunction

  assign accept = cmd_valid && cmd_ready_reg;
  assign chan_m1 = cmd_chan - 5'h01;
  assign dac_idx = chan_m1[2:0];
  assign dac_ok = (cmd_chan >= 5'h01) && ({27'h0, cmd_chan} <= NUM_DAC);
  assign raw_sel = raw_w[conv_idx_reg];

  // ****************************************
  // Input converter units
  // ****************************************
  conv_if cif [NC] ();

  generate
    for (genvar g = 0; g < NC; g++) begin : g_conv
      assign cif[g].sel_valid = sel_valid_reg[g];
      assign cif[g].sel_code = sel_code_reg;
      assign cif[g].start = start_reg[g];
      assign eoc_flags[g] = cif[g].eoc_flag;
      assign raw_w[g] = cif[g].raw;
      conv_unit u_conv (
        .clk(clk),
        .reset_n(reset_n),
        .cif(cif[g]),
        .mux_sel_reg(conv_mux_sel[g]),
        .start_pin_reg(conv_start[g]),
        .eoc_pin(conv_eoc[g]),
        .data_pin(conv_data[g])
      );
    end
  endgenerate

  // ****************************************
  // Output converters
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_hold_reg <= '0;
    end else if (accept && dac_ok && (cmd_op == converter_pkg::OP_DAC_NOW || cmd_op == converter_pkg::OP_DAC_WRITE)) begin
      dac_hold_reg[dac_idx] <= clamp_code(cmd_value);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_code_reg <= '0;
      dac_load_reg <= 1'b0;
    end else begin
      dac_load_reg <= 1'b0;
      if (accept && dac_ok && cmd_op == converter_pkg::OP_DAC_NOW) begin
        dac_code_reg[dac_idx] <= clamp_code(cmd_value);
        dac_load_reg <= 1'b1;
      end else if (accept && cmd_op == converter_pkg::OP_DAC_UPDATE) begin
        dac_code_reg <= dac_hold_reg;
        dac_load_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= converter_pkg::ST_IDLE;
      cmd_ready_reg <= 1'b0;
      settle_cnt_reg <= '0;
      sel_valid_reg <= '0;
      sel_code_reg <= '0;
      start_reg <= '0;
      wait_mask_reg <= '0;
      conv_idx_reg <= 1'b0;
      wide_reg <= 1'b0;
      meas_reg <= 1'b0;
      result_reg <= '0;
      result_valid_reg <= 1'b0;
    end else begin
      sel_valid_reg <= '0;
      start_reg <= '0;
      result_valid_reg <= 1'b0;
      unique case (state_reg)
        converter_pkg::ST_IDLE: begin
          cmd_ready_reg <= 1'b1;
          if (accept) begin
            cmd_ready_reg <= 1'b0;
            state_reg <= converter_pkg::ST_FINISH;
            case (cmd_op)
              converter_pkg::OP_MEASURE, converter_pkg::OP_MEASURE_WIDE: begin
                // Odd inputs on converter 1, even on converter 2; bad channels give junk
                conv_idx_reg <= chan_m1[0];
                wide_reg <= (cmd_op == converter_pkg::OP_MEASURE_WIDE);
                meas_reg <= 1'b1;
                sel_code_reg <= chan_m1[3:1];
                sel_valid_reg[chan_m1[0]] <= 1'b1;
                settle_cnt_reg <= 16'(SETTLE_CYC);
                state_reg <= converter_pkg::ST_SETTLE;
              end
              converter_pkg::OP_READ, converter_pkg::OP_READ_WIDE: begin
                result_reg <= format_result(raw_w[cmd_chan[1]], cmd_op == converter_pkg::OP_READ_WIDE);
                result_valid_reg <= 1'b1;
              end
              converter_pkg::OP_SELECT_CONV1, converter_pkg::OP_SELECT_CONV2: begin
                sel_code_reg <= cmd_value[2:0];
                sel_valid_reg[cmd_op == converter_pkg::OP_SELECT_CONV2] <= 1'b1;
              end
              converter_pkg::OP_START: begin
                start_reg <= cmd_value[1:0];
              end
              converter_pkg::OP_WAIT: begin
                wait_mask_reg <= cmd_value[1:0];
                state_reg <= converter_pkg::ST_WAIT_EOC;
              end
              default: begin
              end
            endcase
          end
        end
        converter_pkg::ST_SETTLE: begin
          if (settle_cnt_reg <= 16'h0001) begin
            start_reg[conv_idx_reg] <= 1'b1;
            state_reg <= converter_pkg::ST_CONVERT;
          end
          settle_cnt_reg <= settle_cnt_reg - 16'h0001;
        end
        converter_pkg::ST_CONVERT: begin
          // One cycle for the unit to drop its end flag
          wait_mask_reg <= '0;
          wait_mask_reg[conv_idx_reg] <= 1'b1;
          state_reg <= converter_pkg::ST_WAIT_EOC;
        end
        converter_pkg::ST_WAIT_EOC: begin
          if ((eoc_flags & wait_mask_reg) == wait_mask_reg) begin
            state_reg <= converter_pkg::ST_FINISH;
            if (meas_reg) begin
              // Measurement path ends here: return offset-binary result
              result_reg <= format_result(raw_sel, wide_reg);
              result_valid_reg <= 1'b1;
            end
          end
        end
        converter_pkg::ST_FINISH: begin
          meas_reg <= 1'b0;
          state_reg <= converter_pkg::ST_IDLE;
          cmd_ready_reg <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence measure_taken;
    accept && (cmd_op == converter_pkg::OP_MEASURE || cmd_op == converter_pkg::OP_MEASURE_WIDE);
  endsequence

  sequence select_then_settle;
    ##1 (sel_valid_reg != '0) && (state_reg == converter_pkg::ST_SETTLE);
  endsequence

  clamp_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && dac_ok && cmd_op == converter_pkg::OP_DAC_NOW && cmd_value < 0) |=> dac_code_reg[$past(dac_idx)] == 16'h0000)
    else $error("negative output code not clamped to zero");
  clamp_high_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && dac_ok && cmd_op == converter_pkg::OP_DAC_NOW && cmd_value > converter_pkg::DAC_CODE_MAX)
    |=> dac_code_reg[$past(dac_idx)] == 16'hFFFF)
    else $error("large output code not clamped to maximum");
  dac_now_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && dac_ok && cmd_op == converter_pkg::OP_DAC_NOW) |=> dac_load_reg ##1 !dac_load_reg)
    else $error("immediate output did not load once");
  buffer_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && cmd_op == converter_pkg::OP_DAC_WRITE) |=> $stable(dac_code_reg) && !dac_load_reg)
    else $error("buffered write changed an output");
  update_all_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && cmd_op == converter_pkg::OP_DAC_UPDATE) |=> dac_code_reg == $past(dac_hold_reg))
    else $error("update did not move all holding registers");
  measure_seq_a: assert property (@(posedge clk) disable iff (!reset_n)
    measure_taken |-> select_then_settle)
    else $error("measurement did not select before settling");
  settle_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == converter_pkg::ST_CONVERT) |-> $past(state_reg) == converter_pkg::ST_SETTLE && $past(settle_cnt_reg) <= 16'h0001)
    else $error("conversion started before settling ended");
  wait_block_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_reg == converter_pkg::ST_WAIT_EOC && (eoc_flags & wait_mask_reg) != wait_mask_reg) |=> state_reg == converter_pkg::ST_WAIT_EOC)
    else $error("wait ended before end of conversion");
  wide_format_a: assert property (@(posedge clk) disable iff (!reset_n)
    (result_valid_reg && result_reg[31:24] != 8'h00) |-> 1'b0)
    else $error("wide result top byte not zero");
  narrow_read_a: assert property (@(posedge clk) disable iff (!reset_n)
    (accept && cmd_op == converter_pkg::OP_READ) |=> result_valid_reg && result_reg[31:16] == 16'h0000)
    else $error("narrow read did not return a 16-bit value");

endmodule
`default_nettype wire

// ===== conv_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Two converters: start pulse to end flag
// ****************************************
module conv_model #(
  parameter int DELAY0 = 3,
  parameter int DELAY1 = 12
) (
  // Clock
  input wire logic clk,
  // Converter pins
  input wire logic [1:0] start,
  input wire logic [1:0][17:0] raw_in,
  output logic [1:0] eoc,
  output logic [1:0][17:0] data
);
  int cnt [2] = '{0, 0};
  int hold [2] = '{0, 0};

  initial begin
    eoc = 2'h3;
    data = '0;
  end

  // Data is held a few cycles past the end flag, then scrambled
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (start[i]) begin
        eoc[i] <= 1'b0;
        cnt[i] <= (i == 0) ? DELAY0 : DELAY1;
      end else if (cnt[i] == 1) begin
        data[i] <= raw_in[i];
        eoc[i] <= 1'b1;
        hold[i] <= 6;
        cnt[i] <= 0;
      end else if (cnt[i] > 1) begin
        cnt[i] <= cnt[i] - 1;
      end
      if (hold[i] == 1) begin
        data[i] <= ~data[i];
      end
      if (hold[i] > 0) begin
        hold[i] <= hold[i] - 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test_analog_io_converter_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_analog_io_converter_control;
  localparam int SETTLE = 2;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [3:0] cmd_op = 4'h0;
  logic [4:0] cmd_chan = 5'h00;
  logic signed [31:0] cmd_value = 32'sh0;
  logic cmd_ready_reg;
  logic [31:0] result_reg;
  logic result_valid_reg;
  logic [1:0][15:0] dac_code_reg;
  logic dac_load_reg;
  logic [1:0][2:0] conv_mux_sel;
  logic [1:0] conv_start;
  logic [1:0] conv_eoc;
  logic [1:0][17:0] conv_data;
  logic [1:0][17:0] raw_in = '0;
  logic [1:0][2:0] last_sel = '0;
  logic [1:0] last_start = 2'h0;
  logic [31:0] r;
  int cyc = 0;
  int t_mux = 0;
  int gap = 0;
  int err_count = 0;
  int n_compared = 0;

  always #50 clk = ~clk;

  analog_io_converter_control #(.NUM_DAC(2), .SETTLE_CYC(SETTLE)) uut (
    .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_chan(cmd_chan),
    .cmd_value(cmd_value), .cmd_ready_reg(cmd_ready_reg), .result_reg(result_reg),
    .result_valid_reg(result_valid_reg), .dac_code_reg(dac_code_reg), .dac_load_reg(dac_load_reg),
    .conv_mux_sel(conv_mux_sel), .conv_start(conv_start), .conv_eoc(conv_eoc), .conv_data(conv_data)
  );

  conv_model #(.DELAY0(3), .DELAY1(12)) partner (
    .clk(clk), .start(conv_start), .raw_in(raw_in), .eoc(conv_eoc), .data(conv_data)
  );

  // ****************************************
  // Select-to-start spacing and start masks
  // ****************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    last_sel <= conv_mux_sel;
    if (conv_mux_sel !== last_sel) begin
      t_mux <= cyc;
    end
    if (conv_start != 2'h0) begin
      gap <= cyc - t_mux;
      last_start <= conv_start;
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic print_verdict();
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    err_count++;
    $display("MISMATCH t=%0t wait ran out", $time);
    print_verdict();
  endtask

  task automatic send_cmd(input logic [3:0] op, input logic [4:0] ch, input logic signed [31:0] v);
    int i;
    i = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_chan <= ch;
    cmd_value <= v;
    do begin
      @(posedge clk);
      i++;
    end while (cmd_ready_reg !== 1'b1 && i < 300);
    cmd_valid <= 1'b0;
    if (i >= 300) hang();
  endtask

  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (cmd_ready_reg !== 1'b1 && i < 300);
    if (i >= 300) hang();
  endtask

  task automatic wait_result(output logic [31:0] res);
    int i;
    for (i = 0; i < 500; i++) begin
      #1;
      if (result_valid_reg === 1'b1) break;
      @(posedge clk);
    end
    res = result_reg;
    if (i >= 500) hang();
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic dac_case(input logic [4:0] ch, input logic signed [31:0] v, input logic [15:0] e0,
                          input logic [15:0] e1);
    send_cmd(converter_pkg::OP_DAC_NOW, ch, v);
    #1;
    check({16'h0000, dac_code_reg[0]}, {16'h0000, e0});
    check({16'h0000, dac_code_reg[1]}, {16'h0000, e1});
    check({31'h0, dac_load_reg}, {31'h0, ch >= 5'h01 && ch <= 5'h02});
  endtask

  task automatic buffered_case();
    send_cmd(converter_pkg::OP_DAC_WRITE, 5'h01, 32'sh1111);
    send_cmd(converter_pkg::OP_DAC_WRITE, 5'h02, 32'sh2222);
    @(posedge clk);
    #1;
    check({dac_code_reg[1], dac_code_reg[0]}, 32'h04D2FFFF);
    send_cmd(converter_pkg::OP_DAC_UPDATE, 5'h00, 32'sh0);
    #1;
    check({dac_code_reg[1], dac_code_reg[0]}, 32'h22221111);
    check({31'h0, dac_load_reg}, 32'h1);
  endtask

  task automatic measure_case(input logic [4:0] ch, input logic [17:0] raw, input logic wide);
    int c;
    logic [31:0] exp;
    c = (ch[0] == 1'b1) ? 0 : 1;
    raw_in[c] = raw;
    exp = wide ? {8'h00, raw, 6'h00} : {16'h0000, raw[17:2]};
    send_cmd(wide ? converter_pkg::OP_MEASURE_WIDE : converter_pkg::OP_MEASURE, ch, 32'sh0);
    wait_result(r);
    check(r, exp);
    check({29'h0, conv_mux_sel[c]}, 32'((ch - 5'h01) >> 1));
    check({30'h0, last_start}, (c == 0) ? 32'h1 : 32'h2);
    check({31'h0, gap >= SETTLE}, 32'h1);
  endtask

  task automatic manual_case();
    raw_in[0] = 18'h12345;
    raw_in[1] = 18'h2ABCD;
    send_cmd(converter_pkg::OP_SELECT_CONV1, 5'h01, 32'sh3);
    send_cmd(converter_pkg::OP_SELECT_CONV2, 5'h02, 32'sh5);
    repeat (SETTLE + 1) @(posedge clk);
    check({26'h0, conv_mux_sel}, 32'h2B);
    send_cmd(converter_pkg::OP_START, 5'h00, 32'sh3);
    send_cmd(converter_pkg::OP_WAIT, 5'h00, 32'sh3);
    wait_ready();
    check({30'h0, conv_eoc}, 32'h3);
    check({30'h0, last_start}, 32'h3);
    send_cmd(converter_pkg::OP_READ, 5'h01, 32'sh0);
    wait_result(r);
    check(r, {16'h0000, raw_in[0][17:2]});
    send_cmd(converter_pkg::OP_READ_WIDE, 5'h02, 32'sh0);
    wait_result(r);
    check(r, {8'h00, raw_in[1], 6'h00});
    send_cmd(converter_pkg::OP_START, 5'h00, 32'sh2);
    wait_ready();
    #1;
    check({30'h0, last_start}, 32'h2);
    send_cmd(converter_pkg::OP_WAIT, 5'h00, 32'sh2);
    wait_ready();
    check({30'h0, conv_eoc}, 32'h3);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    check(dac_code_reg, 32'h0);
    check({30'h0, conv_start}, 32'h0);
    dac_case(5'h01, 32'sh00011170, 16'hFFFF, 16'h0000);
    dac_case(5'h02, -32'sh5, 16'hFFFF, 16'h0000);
    dac_case(5'h02, 32'sh04D2, 16'hFFFF, 16'h04D2);
    dac_case(5'h00, 32'sh7, 16'hFFFF, 16'h04D2);
    dac_case(5'h03, 32'sh9, 16'hFFFF, 16'h04D2);
    buffered_case();
    for (int ch = 16; ch >= 1; ch--) begin
      measure_case(5'(ch), 18'h20000 + 18'((16 - ch) * 18'h01357), 1'b0);
    end
    measure_case(5'h03, 18'h3FFFF, 1'b1);
    measure_case(5'h04, 18'h20000, 1'b1);
    send_cmd(converter_pkg::OP_MEASURE, 5'h00, 32'sh0);
    manual_case();
    print_verdict();
  end
endmodule
`default_nettype wire
